// [design/psb_pkg.sv]
// Shared constants, types and carriers of the power sequencing and status bank
package psb_pkg;

  // Command codes of the bank
  localparam logic [7:0] CMD_PG_THRESH = 8'h5E;
  localparam logic [7:0] CMD_ON_DELAY  = 8'h60;
  localparam logic [7:0] CMD_ON_RISE   = 8'h61;
  localparam logic [7:0] CMD_OFF_DELAY = 8'h64;
  localparam logic [7:0] CMD_OFF_FALL  = 8'h65;
  localparam logic [7:0] CMD_SUM_BYTE  = 8'h78;
  localparam logic [7:0] CMD_SUM_WORD  = 8'h79;
  localparam logic [7:0] CMD_VOUT_FLG  = 8'h7A;
  localparam logic [7:0] CMD_IOUT_FLG  = 8'h7B;
  localparam logic [7:0] CMD_SUPPLY_FLG = 8'h7C;

  // Reset values, power-good strap scale and strap settle count
  localparam logic [15:0] RST_DELAY     = 16'hCA80;
  localparam logic [15:0] RST_RAMP      = 16'hD280;
  localparam logic [7:0]  RST_FLAGS     = 8'h00;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [4:0]  PG_NUM        = 5'h09;
  localparam logic [4:0]  PG_DEN        = 5'h0A;
  localparam logic [1:0]  STRAP_SETTLE  = 2'h2;

  // Range limits in milliseconds
  localparam int DELAY_MAX_MS = 500;
  localparam int RAMP_MAX_MS  = 200;

  // Timing base
  localparam int MS_NS      = 1000000;
  localparam int CLK_NS     = 10;
  localparam int MS_CYCLES  = MS_NS / CLK_NS;

  // Summary byte / word bit positions
  localparam int SB_BUSY = 7;
  localparam int SB_OFF  = 6;
  localparam int SB_VOV  = 5;
  localparam int SB_IOC  = 4;
  localparam int SB_VUV  = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_COMM = 1;
  localparam int SB_NOTA = 0;
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_INP  = 13;
  localparam int SW_VEND = 12;
  localparam int SW_PGN  = 11;
  localparam int SW_FANS = 10;
  localparam int SW_OTH  = 9;
  localparam int SW_UNK  = 8;

  // Detail flag positions (bits 3:0 unused, iout bit 5 reserved)
  localparam logic [7:0] VOUT_USED_MASK = 8'hF0;
  localparam logic [7:0] IOUT_USED_MASK = 8'hD0;
  localparam logic [7:0] SUPPLY_USED_MASK = 8'hF0;
  localparam logic [7:0] SUPPLY_WARN_MASK = 8'h60;

  typedef enum logic [5:0] {
    SEQ_OFF       = 6'b00_0001,
    SEQ_ON_DELAY  = 6'b00_0010,
    SEQ_RISE      = 6'b00_0100,
    SEQ_ON        = 6'b00_1000,
    SEQ_OFF_DELAY = 6'b01_0000,
    SEQ_FALL      = 6'b10_0000
  } psb_seq_t;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic        clrFaults;
    logic [7:0]  code;
    logic [15:0] wrData;
  } psb_cmd_t;

  typedef struct packed {
    logic        rdValid;
    logic        known;
    logic [15:0] rdData;
  } psb_rsp_t;

  // Fault events from the monitors, one-cycle or level, same clock
  typedef struct packed {
    logic [7:0] voutFlags;
    logic [7:0] ioutFlags;
    logic [7:0] supplyFlags;
    logic       busy;
    logic       temperature;
    logic       commLogicMemoryFlag;
    logic       vendorCategoryFlag;
    logic       fans;
    logic       other;
    logic       unknown;
    logic       noneOfAbove;
  } psb_evt_t;

endpackage

// [design/psb_power_seq_bank.sv]
// Command registers, power-good, on/off sequencer and fault status of the converter
`timescale 1ns/1ns
module psb_power_seq_bank #(
  parameter int MS_CYC = psb_pkg::MS_CYCLES
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire psb_pkg::psb_cmd_t cmd,
  output      psb_pkg::psb_rsp_t rsp,
  input  wire logic             enablePin,
  input  wire logic [15:0]      outputSetpointStrap,
  input  wire logic [15:0]      outputVoltage,
  input  wire logic [15:0]      outputUndervoltFaultThreshold,
  input  wire psb_pkg::psb_evt_t evt,
  output      logic             powerGood,
  output      logic             railOn,
  output      logic             rampUp,
  output      logic             rampDown,
  output      logic             hostAlert
);
  import psb_pkg::*;

  // Refused at elaboration: counter and clamp arithmetic assume this range
  if (MS_CYC < 1 || MS_CYC > 1000000) begin : g_bad_ms_cyc
    $error("MS_CYC out of range");
  end

  typedef struct packed {
    logic        enSync1;
    logic        enSync2;
    logic [15:0] strapSync1;
    logic [15:0] strapSync2;
    logic [1:0]  strapCnt;
    logic        strapLoaded;
    logic [15:0] pgThresh;
    logic [15:0] onDelay;
    logic [15:0] onRise;
    logic [15:0] offDelay;
    logic [15:0] offFall;
    logic [7:0]  voutFlags;
    logic [7:0]  ioutFlags;
    logic [7:0]  supplyFlags;
    logic        busy;
    logic        temperature;
    logic        comm;
    logic        vendor;
    logic        fans;
    logic        other;
    logic        unknown;
    logic        nota;
    logic        pg;
    psb_seq_t    seq;
    logic [31:0] cnt;
    logic        railOn;
    logic        rampUp;
    logic        rampDown;
    logic        alert;
    psb_rsp_t    rsp;
  } psb_state_t;

  psb_state_t st_ff;
  psb_state_t nxt_st;

  // Linear-11 time in ms to clock cycles, clamped to the legal range
  function automatic logic [31:0] linElevenToCycles(input logic [15:0] val,
                                                     input int maxMs);
    logic signed [4:0]  ex;
    logic signed [10:0] mant;
    logic [63:0]        prod;
    logic [63:0]        lim;
    ex   = val[15:11];
    mant = val[10:0];
    lim  = 64'(maxMs) * 64'(MS_CYC);
    if (mant < 0) begin
      prod = 64'h0000_0000_0000_0000;
    end else begin
      prod = 64'(mant) * 64'(MS_CYC);
      if (ex < 0) begin
        prod = prod >> (-ex);
      end else begin
        prod = prod << ex;
      end
    end
    if (prod > lim) begin
      prod = lim;
    end
    return prod[31:0];
  endfunction

  logic [7:0]  sumByte;
  logic [15:0] sumWord;
  logic        unpowered;

  // One storage feeds both summary reads
  always_comb begin
    unpowered = (st_ff.seq == SEQ_OFF) || (st_ff.seq == SEQ_ON_DELAY);
    sumByte = 8'h00;
    sumByte[SB_BUSY] = st_ff.busy;
    sumByte[SB_OFF]  = unpowered;
    sumByte[SB_VOV]  = st_ff.voutFlags[7];
    sumByte[SB_IOC]  = st_ff.ioutFlags[7];
    sumByte[SB_VUV]  = st_ff.supplyFlags[4];
    sumByte[SB_TEMP] = st_ff.temperature;
    sumByte[SB_COMM] = st_ff.comm;
    sumByte[SB_NOTA] = st_ff.nota;
    sumWord = {8'h00, sumByte};
    sumWord[SW_VOUT] = |st_ff.voutFlags;
    sumWord[SW_IOUT] = |st_ff.ioutFlags;
    sumWord[SW_INP]  = |st_ff.supplyFlags;
    sumWord[SW_VEND] = st_ff.vendor;
    sumWord[SW_PGN]  = ~st_ff.pg;
    sumWord[SW_FANS] = st_ff.fans;
    sumWord[SW_OTH]  = st_ff.other;
    sumWord[SW_UNK]  = st_ff.unknown;
  end

  logic [19:0] pgScaled;
  logic        clr;
  logic [7:0]  newVout;
  logic [7:0]  newIout;
  logic [7:0]  newSupply;
  logic        newNota;
  logic        anyNew;

  always_comb begin
    nxt_st = st_ff;
    clr    = cmd.clrFaults;
    // Enable and strap are pins, so both pass two flops first
    nxt_st.enSync1    = enablePin;
    nxt_st.enSync2    = st_ff.enSync1;
    nxt_st.strapSync1 = outputSetpointStrap;
    nxt_st.strapSync2 = st_ff.strapSync1;
    pgScaled = (20'(st_ff.strapSync2) * 20'(PG_NUM)) / 20'(PG_DEN);

    // Register writes; status codes are read-only and ignore writes
    if (cmd.wrEn) begin
      unique case (cmd.code)
        CMD_PG_THRESH: nxt_st.pgThresh = cmd.wrData;
        CMD_ON_DELAY:  nxt_st.onDelay  = cmd.wrData;
        CMD_ON_RISE:   nxt_st.onRise   = cmd.wrData;
        CMD_OFF_DELAY: nxt_st.offDelay = cmd.wrData;
        CMD_OFF_FALL:  nxt_st.offFall  = cmd.wrData;
        default: ;
      endcase
    end
    // Strap caught once, after the synchroniser has settled
    if (!st_ff.strapLoaded) begin
      if (st_ff.strapCnt == STRAP_SETTLE) begin
        nxt_st.pgThresh    = pgScaled[15:0];
        nxt_st.strapLoaded = 1'b1;
      end else begin
        nxt_st.strapCnt = st_ff.strapCnt + 2'h1;
      end
    end

    // Hysteresis between the two thresholds
    if (outputVoltage > st_ff.pgThresh) begin
      nxt_st.pg = 1'b1;
    end else if (outputVoltage < outputUndervoltFaultThreshold) begin
      nxt_st.pg = 1'b0;
    end

    // Sequencer; a zero time advances after one cycle
    unique case (st_ff.seq)
      SEQ_OFF: begin
        if (st_ff.enSync2) begin
          nxt_st.seq = SEQ_ON_DELAY;
          nxt_st.cnt = linElevenToCycles(st_ff.onDelay, DELAY_MAX_MS);
        end
      end
      SEQ_ON_DELAY: begin
        if (!st_ff.enSync2) begin
          nxt_st.seq = SEQ_OFF;
        end else if (st_ff.cnt == 32'h0000_0000) begin
          nxt_st.seq = SEQ_RISE;
          nxt_st.cnt = linElevenToCycles(st_ff.onRise, RAMP_MAX_MS);
        end else begin
          nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
        end
      end
      SEQ_RISE: begin
        if (!st_ff.enSync2) begin
          nxt_st.seq = SEQ_OFF_DELAY;
          nxt_st.cnt = linElevenToCycles(st_ff.offDelay, DELAY_MAX_MS);
        end else if (st_ff.cnt == 32'h0000_0000) begin
          nxt_st.seq = SEQ_ON;
        end else begin
          nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
        end
      end
      SEQ_ON: begin
        if (!st_ff.enSync2) begin
          nxt_st.seq = SEQ_OFF_DELAY;
          nxt_st.cnt = linElevenToCycles(st_ff.offDelay, DELAY_MAX_MS);
        end
      end
      SEQ_OFF_DELAY: begin
        if (st_ff.cnt == 32'h0000_0000) begin
          nxt_st.seq = SEQ_FALL;
          nxt_st.cnt = linElevenToCycles(st_ff.offFall, RAMP_MAX_MS);
        end else begin
          nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
        end
      end
      SEQ_FALL: begin
        // Fall runs to completion; a re-enable is taken from off
        if (st_ff.cnt == 32'h0000_0000) begin
          nxt_st.seq = SEQ_OFF;
        end else begin
          nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
        end
      end
      default: begin
        nxt_st.seq = SEQ_OFF;
        nxt_st.cnt = 32'h0000_0000;
      end
    endcase
    // Rail outputs get flops of their own, loaded from the next state
    nxt_st.railOn   = !((nxt_st.seq == SEQ_OFF) || (nxt_st.seq == SEQ_ON_DELAY));
    nxt_st.rampUp   = (nxt_st.seq == SEQ_RISE);
    nxt_st.rampDown = (nxt_st.seq == SEQ_FALL);

    // Latched faults: clear first, then events, so a same-cycle event survives
    newVout   = evt.voutFlags & VOUT_USED_MASK;
    newIout   = evt.ioutFlags & IOUT_USED_MASK;
    newSupply = evt.supplyFlags & SUPPLY_USED_MASK;
    newNota   = evt.noneOfAbove | (|(newSupply & SUPPLY_WARN_MASK));
    if (clr) begin
      nxt_st.voutFlags   = RST_FLAGS;
      nxt_st.ioutFlags   = RST_FLAGS;
      nxt_st.supplyFlags = RST_FLAGS;
      nxt_st.busy        = 1'b0;
      nxt_st.temperature = 1'b0;
      nxt_st.comm        = 1'b0;
      nxt_st.vendor      = 1'b0;
      nxt_st.fans        = 1'b0;
      nxt_st.other       = 1'b0;
      nxt_st.unknown     = 1'b0;
      nxt_st.nota        = 1'b0;
      nxt_st.alert       = 1'b0;
    end
    // Alert only on bits not already latched, so a held fault does not re-notify;
    // taken after the clear, so an event in the clearing cycle alerts again
    anyNew = (|(newVout & ~nxt_st.voutFlags)) | (|(newIout & ~nxt_st.ioutFlags))
           | (|(newSupply & ~nxt_st.supplyFlags)) | (evt.busy & ~nxt_st.busy)
           | (evt.temperature & ~nxt_st.temperature)
           | (evt.commLogicMemoryFlag & ~nxt_st.comm)
           | (evt.vendorCategoryFlag & ~nxt_st.vendor) | (evt.fans & ~nxt_st.fans)
           | (evt.other & ~nxt_st.other) | (evt.unknown & ~nxt_st.unknown)
           | (newNota & ~nxt_st.nota);
    nxt_st.voutFlags   = nxt_st.voutFlags | newVout;
    nxt_st.ioutFlags   = nxt_st.ioutFlags | newIout;
    nxt_st.supplyFlags = nxt_st.supplyFlags | newSupply;
    nxt_st.busy        = nxt_st.busy | evt.busy;
    nxt_st.temperature = nxt_st.temperature | evt.temperature;
    nxt_st.comm        = nxt_st.comm | evt.commLogicMemoryFlag;
    nxt_st.vendor      = nxt_st.vendor | evt.vendorCategoryFlag;
    nxt_st.fans        = nxt_st.fans | evt.fans;
    nxt_st.other       = nxt_st.other | evt.other;
    nxt_st.unknown     = nxt_st.unknown | evt.unknown;
    nxt_st.nota        = nxt_st.nota | newNota;
    nxt_st.alert = nxt_st.alert | anyNew;

    // Reads answer one cycle later; unknown codes read zero
    nxt_st.rsp.rdValid = cmd.rdEn;
    nxt_st.rsp.known   = 1'b1;
    nxt_st.rsp.rdData  = RST_WORD;
    if (cmd.rdEn) begin
      unique case (cmd.code)
        CMD_PG_THRESH:  nxt_st.rsp.rdData = st_ff.pgThresh;
        CMD_ON_DELAY:   nxt_st.rsp.rdData = st_ff.onDelay;
        CMD_ON_RISE:    nxt_st.rsp.rdData = st_ff.onRise;
        CMD_OFF_DELAY:  nxt_st.rsp.rdData = st_ff.offDelay;
        CMD_OFF_FALL:   nxt_st.rsp.rdData = st_ff.offFall;
        CMD_SUM_BYTE:   nxt_st.rsp.rdData = {8'h00, sumByte};
        CMD_SUM_WORD:   nxt_st.rsp.rdData = sumWord;
        CMD_VOUT_FLG:   nxt_st.rsp.rdData = {8'h00, st_ff.voutFlags};
        CMD_IOUT_FLG:   nxt_st.rsp.rdData = {8'h00, st_ff.ioutFlags};
        CMD_SUPPLY_FLG: nxt_st.rsp.rdData = {8'h00, st_ff.supplyFlags};
        default:        nxt_st.rsp.known  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_ff             <= '0;
      st_ff.onDelay     <= RST_DELAY;
      st_ff.offDelay    <= RST_DELAY;
      st_ff.onRise      <= RST_RAMP;
      st_ff.offFall     <= RST_RAMP;
      st_ff.voutFlags   <= RST_FLAGS;
      st_ff.ioutFlags   <= RST_FLAGS;
      st_ff.supplyFlags <= RST_FLAGS;
      st_ff.seq         <= SEQ_OFF;
      st_ff.rsp         <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp       = st_ff.rsp;
  assign powerGood = st_ff.pg;
  assign rampUp    = st_ff.rampUp;
  assign rampDown  = st_ff.rampDown;
  assign railOn    = st_ff.railOn;
  assign hostAlert = st_ff.alert;

endmodule

// [verif/psb_bank_chk.sv]
// Port-level assertions of the power sequencing and status bank
`timescale 1ns/1ns
module psb_bank_chk #(
  parameter int MS_CYC = 2
) (
  input wire logic              mclk,
  input wire logic              nrst,
  input wire psb_pkg::psb_cmd_t cmd,
  input wire psb_pkg::psb_rsp_t rsp,
  input wire logic [15:0]       outputVoltage,
  input wire logic [15:0]       outputUndervoltFaultThreshold,
  input wire psb_pkg::psb_evt_t evt,
  input wire logic              powerGood,
  input wire logic              railOn,
  input wire logic              rampUp,
  input wire logic              rampDown,
  input wire logic              hostAlert
);
  import psb_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_word_pg_inv: assert property (
    cmd.rdEn && cmd.code == CMD_SUM_WORD |=> rsp.rdData[SW_PGN] == !$past(powerGood))
    else $error("word bit 11 differs from inverted power good");
  a_off_bit: assert property (
    cmd.rdEn && cmd.code == CMD_SUM_BYTE |=> rsp.rdData[SB_OFF] == !$past(railOn))
    else $error("off bit differs from rail state");
  a_vout_unused: assert property (
    cmd.rdEn && cmd.code == CMD_VOUT_FLG |=> (rsp.rdData & 16'hFF0F) == 16'h0000)
    else $error("voltage flags unused bits set");
  a_iout_reserved: assert property (
    cmd.rdEn && cmd.code == CMD_IOUT_FLG |=> (rsp.rdData & 16'hFF2F) == 16'h0000)
    else $error("current flags reserved bits set");
  a_supply_unused: assert property (
    cmd.rdEn && cmd.code == CMD_SUPPLY_FLG |=> (rsp.rdData & 16'hFF0F) == 16'h0000)
    else $error("supply flags unused bits set");
  // Past reset guard keeps a reset-forced drop from counting
  a_pg_hysteresis: assert property (
    $fell(powerGood) && $past(nrst) |->
      $past(outputVoltage) < $past(outputUndervoltFaultThreshold))
    else $error("power good dropped above undervolt threshold");
  a_rise_start: assert property (
    $rose(rampUp) && $past(nrst) |-> $rose(railOn))
    else $error("rise began without rail turning on");
  a_fall_end: assert property (
    $fell(rampDown) && $past(nrst) |-> $fell(railOn))
    else $error("fall ended without rail turning off");
  a_alert_hold: assert property (
    hostAlert && !cmd.clrFaults |=> hostAlert)
    else $error("alert dropped without clear");
  a_warn_alert: assert property (
    (evt.supplyFlags & SUPPLY_WARN_MASK) != 8'h00 |=> hostAlert)
    else $error("supply warning raised no alert");
endmodule

// [verif/psb_host_model.sv]
// Host model issuing command register accesses and clear-faults
`timescale 1ns/1ns
module psb_host_model (
  input  wire logic              mclk,
  output      psb_pkg::psb_cmd_t cmd,
  input  wire psb_pkg::psb_rsp_t rsp
);
  import psb_pkg::*;
  initial cmd = '0;
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge mclk);
    cmd.code   <= code;
    cmd.wrData <= data;
    cmd.wrEn   <= 1'b1;
    @(posedge mclk);
    cmd.wrEn   <= 1'b0;
    cmd.wrData <= ~data;
  endtask
  // Released fields are inverted so stale values never pass
  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic known);
    @(posedge mclk);
    cmd.code <= code;
    cmd.rdEn <= 1'b1;
    @(posedge mclk);
    cmd.rdEn <= 1'b0;
    cmd.code <= ~code;
    #1;
    data  = rsp.rdValid ? rsp.rdData : 16'hDEAD;
    known = rsp.known;
  endtask
  task automatic clr();
    @(posedge mclk);
    cmd.clrFaults <= 1'b1;
    @(posedge mclk);
    cmd.clrFaults <= 1'b0;
  endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench of the power sequencing and status bank
`timescale 1ns/1ns
module tb_top;
  import psb_pkg::*;
  localparam int MSC = 2;
  localparam logic [7:0] RC [10] = '{CMD_ON_DELAY, CMD_ON_RISE, CMD_OFF_DELAY,
    CMD_OFF_FALL, CMD_SUM_BYTE, CMD_SUM_WORD, CMD_VOUT_FLG, CMD_IOUT_FLG,
    CMD_SUPPLY_FLG, CMD_PG_THRESH};
  localparam logic [15:0] RV [10] = '{RST_DELAY, RST_RAMP, RST_DELAY, RST_RAMP,
    16'h0040, 16'h0840, 16'h0000, 16'h0000, 16'h0000, 16'h0E66};
  localparam logic [31:0] EV [15] = '{32'h8000_0000, 32'h1000_0000, 32'h0080_0000,
    32'h0040_0000, 32'h0020_0000, 32'h0000_1000, 32'h0000_4000, 32'h0000_0080,
    32'h0000_0040, 32'h0000_0020, 32'h0000_0010, 32'h0000_0008, 32'h0000_0004,
    32'h0000_0002, 32'h0000_0001};
  localparam logic [15:0] EW [15] = '{16'h8860, 16'h8840, 16'h4850, 16'h4840,
    16'h0840, 16'h2848, 16'h2841, 16'h08C0, 16'h0844, 16'h0842, 16'h1840,
    16'h0C40, 16'h0A40, 16'h0940, 16'h0841};
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  psb_cmd_t    cmd;
  psb_rsp_t    rsp;
  logic        enablePin = 1'b0;
  logic [15:0] strap = 16'h1000;
  logic [15:0] vout = 16'h0000;
  logic [15:0] uvLim = 16'h0800;
  psb_evt_t    evt = '0;
  logic        powerGood, railOn, rampUp, rampDown, hostAlert;
  logic [15:0] rd;
  logic        kn;
  int          n;
  int          cyc = 0;
  int          err_count = 0;
  int          check_count = 0;

  psb_power_seq_bank #(.MS_CYC(MSC)) uut (
    .mclk(mclk), .nrst(nrst), .cmd(cmd), .rsp(rsp), .enablePin(enablePin),
    .outputSetpointStrap(strap), .outputVoltage(vout),
    .outputUndervoltFaultThreshold(uvLim), .evt(evt), .powerGood(powerGood),
    .railOn(railOn), .rampUp(rampUp), .rampDown(rampDown), .hostAlert(hostAlert));
  psb_host_model host (.mclk(mclk), .cmd(cmd), .rsp(rsp));

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] code, input logic [15:0] exp);
    host.rd(code, rd, kn);
    chk(rd, exp);
    chk({15'h0000, kn}, 16'h0001);
  endtask
  // Bounded wait; k counts settled edges until the chosen ramp output reaches v
  task automatic count(input logic dn, input logic v, output int k);
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (((dn ? rampDown : rampUp) !== v) && k < 3000);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 10; i++) rdc(RC[i], RV[i]);
    host.rd(8'h70, rd, kn);
    chk(rd, 16'h0000);
    chk({15'h0000, kn}, 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 5; i++) host.wr(RC[i], 16'hA5C3 ^ 16'(i));
    host.wr(CMD_SUM_BYTE, 16'hFFFF);
    for (int i = 0; i < 5; i++) rdc(RC[i], (i < 4) ? (16'hA5C3 ^ 16'(i)) : 16'h0040);
    $display("register access done");
    for (int i = 0; i < 15; i++) begin
      @(posedge mclk) evt <= EV[i];
      @(posedge mclk) evt <= '0;
      rdc(CMD_SUM_WORD, EW[i]);
      rdc(CMD_SUM_BYTE, {8'h00, EW[i][7:0]});
      chk({15'h0000, hostAlert}, {15'h0000, EW[i] != 16'h0840});
      host.clr();
      rdc(CMD_SUM_WORD, 16'h0840);
      chk({15'h0000, hostAlert}, 16'h0000);
    end
    @(posedge mclk) evt <= 32'hFFFF_FF00;
    @(posedge mclk) evt <= '0;
    host.wr(CMD_VOUT_FLG, 16'h0000);
    rdc(CMD_VOUT_FLG, 16'h00F0);
    rdc(CMD_IOUT_FLG, 16'h00D0);
    rdc(CMD_SUPPLY_FLG, 16'h00F0);
    host.clr();
    $display("fault status done");
    host.wr(CMD_PG_THRESH, 16'h0E66);
    host.wr(CMD_ON_DELAY, 16'hF806);
    host.wr(CMD_ON_RISE, 16'hF804);
    host.wr(CMD_OFF_DELAY, 16'hFBFF);
    host.wr(CMD_OFF_FALL, 16'h0000);
    @(posedge mclk) enablePin <= 1'b1;
    // Two synchroniser edges and the state entry edge come before the count
    count(1'b0, 1'b1, n);
    chk(16'(n), 16'(3 * MSC + 4));
    count(1'b0, 1'b0, n);
    chk(16'(n), 16'(2 * MSC + 1));
    chk({15'h0000, railOn}, 16'h0001);
    rdc(CMD_SUM_BYTE, 16'h0000);
    $display("turn on done");
    @(posedge mclk) vout <= 16'h0E66;
    repeat (2) @(posedge mclk);
    chk({15'h0000, powerGood}, 16'h0000);
    @(posedge mclk) vout <= 16'h0E67;
    repeat (2) @(posedge mclk);
    chk({15'h0000, powerGood}, 16'h0001);
    @(posedge mclk) vout <= 16'h0800;
    rdc(CMD_SUM_WORD, 16'h0000);
    @(posedge mclk) vout <= 16'h07FF;
    repeat (2) @(posedge mclk);
    chk({15'h0000, powerGood}, 16'h0000);
    $display("power good done");
    @(posedge mclk) enablePin <= 1'b0;
    count(1'b1, 1'b1, n);
    chk(16'(n), 16'(DELAY_MAX_MS * MSC + 4));
    count(1'b1, 1'b0, n);
    chk(16'(n), 16'h0001);
    chk({15'h0000, railOn}, 16'h0000);
    rdc(CMD_SUM_BYTE, 16'h0040);
    $display("turn off done");
    final_report();
  end
endmodule

bind psb_power_seq_bank psb_bank_chk #(.MS_CYC(MS_CYC)) u_chk (
  .mclk(mclk), .nrst(nrst), .cmd(cmd), .rsp(rsp), .outputVoltage(outputVoltage),
  .outputUndervoltFaultThreshold(outputUndervoltFaultThreshold), .evt(evt),
  .powerGood(powerGood), .railOn(railOn), .rampUp(rampUp), .rampDown(rampDown),
  .hostAlert(hostAlert));
